// >>> rtl/dpre_pkg.sv
`default_nettype none
package dpre_pkg;
   localparam int AXI_DW      = 32;
   localparam int AXI_AW      = 8;
   localparam int NREG        = 16;
   localparam int WORD_AW     = 4;
   localparam int BYTE_SH     = 2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] REG_RST    = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> rtl/dpre_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dpre_if;
   logic        awvalid;
   logic        awready;
   logic [7:0]  awaddr;
   logic        wvalid;
   logic        wready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        bvalid;
   logic        bready;
   logic [1:0]  bresp;
   logic        arvalid;
   logic        arready;
   logic [7:0]  araddr;
   logic        rvalid;
   logic        rready;
   logic [31:0] rdata;
   logic [1:0]  rresp;

   modport device
   (
      input  awvalid, awaddr, wvalid, wdata, wstrb, bready,
      input  arvalid, araddr, rready,
      output awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp
   );
   modport host
   (
      output awvalid, awaddr, wvalid, wdata, wstrb, bready,
      output arvalid, araddr, rready,
      input  awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp
   );
endinterface
`default_nettype wire

// >>> rtl/dpre_host.sv
`timescale 1ns/1ns
`default_nettype none
// Host bus master end: one single-beat access at a time, started by a
// pulse on the user side, finished by a one-cycle done pulse.
module dpre_host
(
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST,
   // Bus
   dpre_if.host             BUS,
   // User command
   input  wire logic        CMD_GO,
   input  wire logic        CMD_WRITE,
   input  wire logic [7:0]  CMD_ADDR,
   input  wire logic [31:0] CMD_WDATA,
   input  wire logic [3:0]  CMD_STRB,
   // User answer
   output logic             CMD_BUSY,
   output logic             CMD_DONE,
   output logic [31:0]      CMD_RDATA,
   output logic [1:0]       CMD_RESP
);
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_REQ = 2'b01,
                             H_RSP = 2'b11} dpre_hst_t;
   typedef struct packed {
      dpre_hst_t   st;
      logic        wr;
      logic        aw;
      logic        w;
      logic        ar;
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [3:0]  strb;
      logic        done;
      logic [31:0] rdata;
      logic [1:0]  resp;
      logic        rdy;
   } dpre_hs_t;
   dpre_hs_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      unique case (s_q.st)
         H_IDLE:
         begin
            if (CMD_GO)
            begin
               s_d.st = H_REQ;
               s_d.wr = CMD_WRITE;
               s_d.addr = CMD_ADDR;
               s_d.wdata = CMD_WDATA;
               s_d.strb = CMD_STRB;
               s_d.aw = CMD_WRITE;
               s_d.w = CMD_WRITE;
               s_d.ar = !CMD_WRITE;
            end
         end
         H_REQ:
         begin
            if (s_q.aw && BUS.awready) s_d.aw = 1'b0;
            if (s_q.w && BUS.wready) s_d.w = 1'b0;
            if (s_q.ar && BUS.arready) s_d.ar = 1'b0;
            if (!s_d.aw && !s_d.w && !s_d.ar) s_d.st = H_RSP;
         end
         H_RSP:
         begin
            // Ready trails valid by one cycle; the slave must hold
            if (!s_q.rdy)
               s_d.rdy = s_q.wr ? BUS.bvalid : BUS.rvalid;
            else if (s_q.wr && BUS.bvalid)
            begin
               s_d.st = H_IDLE;
               s_d.rdy = 1'b0;
               s_d.done = 1'b1;
               s_d.resp = BUS.bresp;
            end
            else if (!s_q.wr && BUS.rvalid)
            begin
               s_d.st = H_IDLE;
               s_d.rdy = 1'b0;
               s_d.done = 1'b1;
               s_d.rdata = BUS.rdata;
               s_d.resp = BUS.rresp;
            end
         end
         default: s_d.st = H_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // Single beats only, never a burst
   assign BUS.awvalid = s_q.aw;
   assign BUS.awaddr  = s_q.addr;
   assign BUS.wvalid  = s_q.w;
   assign BUS.wdata   = s_q.wdata;
   assign BUS.wstrb   = s_q.strb;
   assign BUS.arvalid = s_q.ar;
   assign BUS.araddr  = s_q.addr;
   assign BUS.bready  = s_q.rdy && s_q.wr;
   assign BUS.rready  = s_q.rdy && !s_q.wr;

   assign CMD_BUSY  = (s_q.st != H_IDLE);
   assign CMD_DONE  = s_q.done;
   assign CMD_RDATA = s_q.rdata;
   assign CMD_RESP  = s_q.resp;
endmodule
`default_nettype wire

// >>> rtl/dpre_device.sv
`timescale 1ns/1ns
`default_nettype none
module dpre_device
#(
   parameter int NREG = dpre_pkg::NREG
)
(
   // Clock and reset
   input  wire logic                  CLOCK,
   input  wire logic                  ACTIVE_LOW_RESET_N,
   // Host bus
   dpre_if.device                     BUS,
   // Sequencer port
   input  wire logic                  SEQ_EN,
   input  wire logic                  SEQ_WE,
   input  wire logic [3:0]            SEQ_ADDR,
   input  wire logic [31:0]           SEQ_WDATA,
   output logic [31:0]                SEQ_RDATA,
   // Status inputs and control vectors
   input  wire logic [NREG-1:0][31:0] STATUS_IN,
   input  wire logic [NREG-1:0]       STATUS_SEL,
   output logic [NREG-1:0][31:0]      CTRL_OUT
);
   typedef struct packed {
      logic [NREG-1:0][31:0] regs;
      logic                  awh;
      logic [7:0]            awa;
      logic                  wh;
      logic [31:0]           wd;
      logic [3:0]            ws;
      logic                  bv;
      logic [1:0]            br;
      logic                  rv;
      logic [31:0]           rd;
      logic [1:0]            rr;
      logic [31:0]           sr;
      logic                  awr;
      logic                  wrr;
      logic                  arr;
   } dpre_ds_t;
   dpre_ds_t s_q, s_d;

   // Byte address to word index, low two bits dropped
   function automatic logic [3:0] widx(input logic [7:0] a);
      widx = a[dpre_pkg::BYTE_SH +: dpre_pkg::WORD_AW];
   endfunction

   // Indices past the last register answer the host with an error; the sequencer reads zero
   function automatic logic inmap(input logic [3:0] i);
      inmap = (32'(i) < NREG);
   endfunction

   // Status words are read-only views; control words are stored
   function automatic logic [31:0] view(input dpre_ds_t s,
                                        input logic [3:0] i);
      view = STATUS_SEL[i] ? STATUS_IN[i] : s.regs[i];
   endfunction

   // Lane k carries byte address offset k
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      merge = old;
      for (int k = 0; k < 4; k++)
      begin
         if (strb[k])
         begin
            merge[8*k +: 8] = data[8*k +: 8];
         end
      end
   endfunction

   // Status words and unmapped indices refuse writes
   function automatic logic wrok(input logic [3:0] i);
      wrok = inmap(i) && !STATUS_SEL[i];
   endfunction

   // Readies stand high through reset so none shows a stale low after it
   function automatic dpre_ds_t rst_state();
      rst_state = '0;
      for (int i = 0; i < NREG; i++)
      begin
         rst_state.regs[i] = dpre_pkg::REG_RST;
      end
      rst_state.awr = 1'b1;
      rst_state.wrr = 1'b1;
      rst_state.arr = 1'b1;
   endfunction

   logic [3:0] hidx;
   logic [3:0] ridx;
   logic       seq_wr;
   logic       host_wr;

   assign hidx    = widx(s_q.awa);
   assign ridx    = widx(BUS.araddr);
   assign seq_wr  = SEQ_EN && SEQ_WE && wrok(SEQ_ADDR);
   assign host_wr = s_q.awh && s_q.wh;

   always_comb
   begin
      s_d = s_q;
      // Address and data may arrive in either order
      if (s_q.awr && BUS.awvalid)
      begin
         s_d.awh = 1'b1;
         s_d.awa = BUS.awaddr;
      end
      if (s_q.wrr && BUS.wvalid)
      begin
         s_d.wh = 1'b1;
         s_d.wd = BUS.wdata;
         s_d.ws = BUS.wstrb;
      end
      if (host_wr)
      begin
         s_d.awh = 1'b0;
         s_d.wh  = 1'b0;
         s_d.bv  = 1'b1;
         if (wrok(hidx))
         begin
            s_d.br = dpre_pkg::RESP_OKAY;
            s_d.regs[hidx] = merge(s_q.regs[hidx], s_q.wd, s_q.ws);
         end
         else
         begin
            s_d.br = dpre_pkg::RESP_SLVERR;
         end
      end
      if (s_q.bv && BUS.bready)
      begin
         s_d.bv = 1'b0;
      end
      if (s_q.arr && BUS.arvalid)
      begin
         s_d.rv = 1'b1;
         if (inmap(ridx))
         begin
            s_d.rd = view(s_q, ridx);
            s_d.rr = dpre_pkg::RESP_OKAY;
         end
         else
         begin
            s_d.rd = '0;
            s_d.rr = dpre_pkg::RESP_SLVERR;
         end
      end
      else if (s_q.rv && BUS.rready)
      begin
         s_d.rv = 1'b0;
      end
      // Sequencer path never waits on the host side
      if (SEQ_EN && inmap(SEQ_ADDR))
      begin
         s_d.sr = view(s_q, SEQ_ADDR); // Old word, even on a write
      end
      else
      begin
         s_d.sr = '0;
      end
      // Applied after the host write so it wins a collision
      if (seq_wr)
      begin
         s_d.regs[SEQ_ADDR] = SEQ_WDATA;
      end
      // Readies follow the slots they guard, one flop each
      s_d.awr = !s_d.awh && !s_d.bv;
      s_d.wrr = !s_d.wh && !s_d.bv;
      s_d.arr = !s_d.rv;
   end

   always_ff @(posedge CLOCK)
   begin
      if (!ACTIVE_LOW_RESET_N)
      begin
         s_q <= rst_state();
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Every output comes straight from its flop
   assign BUS.awready = s_q.awr;
   assign BUS.wready  = s_q.wrr;
   assign BUS.bvalid  = s_q.bv;
   assign BUS.bresp   = s_q.br;
   assign BUS.arready = s_q.arr;
   assign BUS.rvalid  = s_q.rv;
   assign BUS.rdata   = s_q.rd;
   assign BUS.rresp   = s_q.rr;
   assign SEQ_RDATA   = s_q.sr;
   assign CTRL_OUT    = s_q.regs;
endmodule
`default_nettype wire

// >>> verif/dpre_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dpre_sva
(
   // Clock and reset
   input wire logic        CLOCK,
   input wire logic        RST,
   // Write side
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [7:0]  awaddr,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   // Read side
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   sequence s_rd;
      arvalid && arready;
   endsequence
   sequence s_wr;
      wvalid && wready;
   endsequence
   a_rd_next: assert property (s_rd |=> rvalid)
      else $error("read answer late");
   a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_rd_refuse: assert property (rvalid |-> !arready)
      else $error("read taken while busy");
   a_wr_answer: assert property (s_wr |-> ##[1:4] bvalid)
      else $error("write answer late");
   a_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   a_wr_refuse: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while busy");
   a_aw_hold: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
      else $error("address changed early");
   a_one_txn: assert property (rvalid |-> !awvalid && !wvalid)
      else $error("overlapping transfers");
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic              clk, rst, go, wr, sen, swe, busy, done;
   logic [7:0]        addr;
   logic [3:0]        strb, sa;
   logic [31:0]       wd, swd, rd, srd, e;
   logic [1:0]        resp;
   logic [15:0]       ssel;
   logic [15:0][31:0] sin, ctl;
   logic [31:0]       mdl [16];
   int                fail_count, check_count, i, k;
   dpre_if bus ();
   dpre_host dpre_host_inst (.CLOCK(clk), .RST(rst), .BUS(bus),
      .CMD_GO(go), .CMD_WRITE(wr), .CMD_ADDR(addr), .CMD_WDATA(wd),
      .CMD_STRB(strb), .CMD_BUSY(busy), .CMD_DONE(done),
      .CMD_RDATA(rd), .CMD_RESP(resp));
   dpre_device dpre_device_inst (.CLOCK(clk), .ACTIVE_LOW_RESET_N(!rst),
      .BUS(bus), .SEQ_EN(sen), .SEQ_WE(swe), .SEQ_ADDR(sa),
      .SEQ_WDATA(swd), .SEQ_RDATA(srd), .STATUS_IN(sin),
      .STATUS_SEL(ssel), .CTRL_OUT(ctl));
   dpre_sva dpre_sva_inst (.CLOCK(clk), .RST(rst), .awvalid(bus.awvalid),
      .awready(bus.awready), .awaddr(bus.awaddr), .wvalid(bus.wvalid),
      .wready(bus.wready), .bvalid(bus.bvalid), .bready(bus.bready),
      .bresp(bus.bresp), .arvalid(bus.arvalid), .arready(bus.arready),
      .rvalid(bus.rvalid), .rready(bus.rready), .rdata(bus.rdata));
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   function logic [31:0] exw(input int j);
      return ssel[j] ? sin[j] : mdl[j];
   endfunction
   // Host access; waits for done under a bound so a hang still reports
   task host(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [3:0] s);
      int n;
      @(negedge clk);
      go = 1;
      wr = w;
      addr = a;
      wd = d;
      strb = s;
      @(negedge clk);
      go = 0;
      chk({31'h0, busy}, 32'h1);
      n = 0;
      while (done !== 1'b1 && n < 50)
      begin
         @(negedge clk);
         n++;
      end
      k = int'(a[5:2]);
      chk({31'h0, done}, 32'h1);
      chk({31'h0, busy}, 32'h0);
      chk({30'h0, resp}, {30'h0, (w && ssel[k]) ? dpre_pkg::RESP_SLVERR
                                   : dpre_pkg::RESP_OKAY});
      for (n = 0; n < 4; n++)
         if (w && !ssel[k] && s[n])
            mdl[k][8*n +: 8] = d[8*n +: 8];
      if (!w)
         chk(rd, exw(k));
      else if (!ssel[k])
         chk(ctl[k], mdl[k]);
   endtask
   // Sequencer read data shows the word as it stood before the access
   task seq(input logic w, input logic [3:0] a, input logic [31:0] d);
      logic [31:0] old;
      old = exw(a);
      @(negedge clk);
      sen = 1;
      swe = w;
      sa = a;
      swd = d;
      @(negedge clk);
      sen = 0;
      if (w && !ssel[a])
         mdl[a] = d;
      chk(srd, old);
      if (!ssel[a])
         chk(ctl[a], mdl[a]);
   endtask
   initial
   begin
      rst = 1;
      {go, wr, addr, wd, strb, sen, swe, sa, swd} = '0;
      fail_count = 0;
      check_count = 0;
      ssel = 16'hc000;
      for (i = 0; i < 16; i++)
      begin
         sin[i] = 32'h5a5a0000 + i;
         mdl[i] = 32'h0;
      end
      k = $urandom(32'h0391);
      repeat (4) @(negedge clk);
      rst = 0;
      for (i = 0; i < 16; i++)
         seq(1'b0, 4'(i), 32'h0);
      $display("reset values test ended");
      host(1'b1, 8'hf0, 32'habcd0123, 4'hf);
      seq(1'b0, 4'hc, 32'h0);
      for (i = 0; i < 4; i++)
         host(1'b1, 8'h04, $urandom, 4'(1 << i));
      host(1'b1, 8'hfc, 32'h12345678, 4'hf);
      host(1'b0, 8'h3c, 32'h0, 4'h0);
      $display("byte lane test ended");
      // Random mix uses either port on shared words, one access at a time, never both at once
      repeat (80)
      begin
         e = $urandom;
         if (e[0])
            host(e[1], e[15:8], $urandom, e[7:4]);
         else
            seq(e[1], e[11:8], $urandom);
      end
      $display("random mix test ended");
      give_verdict;
   end
   initial
   begin
      #100000;
      fail_count++;
      give_verdict;
   end
endmodule
`default_nettype wire
